//--- rtl/adpp_core.sv
module adpp_core (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic [adpp_pkg::ADPP_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Samples from the converter cores, offset binary
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [adpp_pkg::ADPP_DW-1:0] in_a,
	input wire logic [adpp_pkg::ADPP_DW-1:0] in_b,
	// Processed samples to the formatter
	output logic out_valid,
	input wire logic out_ready,
	output logic [adpp_pkg::ADPP_DW-1:0] out_a,
	output logic [adpp_pkg::ADPP_DW-1:0] out_b
);
	import adpp_pkg::*;

	adpp_state_t s_reg;
	adpp_state_t s_next;

	logic [3:0] gcode;
	logic [2:0] tc;
	logic off_en;
	logic freeze;
	logic filt_en;
	logic [2:0] rate;
	logic [1:0] band;
	logic user;
	logic odd;
	logic lowlat;
	logic filt_on;
	logic [3:0] dec_n;
	logic fire;
	logic emit;
	logic mapped;
	logic [5:0] tc_sh;
	logic [15:0] gain_q;
	logic signed [11:0] hk [12];
	logic signed [11:0] xs [2];
	logic signed [11:0] off_y [2];
	logic signed [11:0] gain_y [2];
	logic signed [11:0] fir_y [2];
	logic signed [11:0] res_y [2];
	logic signed [11:0] est_y [2];

	function automatic logic [11:0] adpp_sat(input int v);
		if (v > 2047) begin
			return 12'h7ff;
		end
		if (v < -2048) begin
			return 12'h800;
		end
		return v[11:0];
	endfunction

	function automatic logic [3:0] adpp_rate_n(input logic [2:0] r);
		case (r)
			ADPP_RATE_D2: return 4'h2;
			ADPP_RATE_D4: return 4'h4;
			ADPP_RATE_D8: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction

	function automatic logic adpp_hit(input logic [7:0] a);
		return a == ADPP_CTRL_ADDR || a == ADPP_STAT_ADDR ||
			(a >= ADPP_COEF_ADDR && a < ADPP_STAT_ADDR && a[1:0] == 2'h0);
	endfunction

	assign gcode = s_reg.ctrl[ADPP_GAIN_LSB +: 4];
	assign tc = s_reg.ctrl[ADPP_TC_LSB +: 3];
	assign off_en = s_reg.ctrl[ADPP_OFF_EN_BIT];
	assign freeze = s_reg.ctrl[ADPP_FREEZE_BIT];
	assign filt_en = s_reg.ctrl[ADPP_FILT_EN_BIT];
	assign rate = s_reg.ctrl[ADPP_RATE_LSB +: 3];
	assign band = s_reg.ctrl[ADPP_BAND_LSB +: 2];
	assign user = s_reg.ctrl[ADPP_USER_BIT];
	assign odd = s_reg.ctrl[ADPP_ODD_BIT];
	assign lowlat = s_reg.ctrl[ADPP_LOWLAT_BIT];

	// Illegal combinations leave the filter out rather than guess a mode
	assign filt_on = !lowlat && (filt_en ? (rate == ADPP_RATE_D2 || rate == ADPP_RATE_D4 ||
		(rate == ADPP_RATE_D8 && user)) : (user && rate == ADPP_RATE_NODEC));
	assign dec_n = filt_on ? adpp_rate_n(rate) : 4'h1;
	assign tc_sh = 6'(ADPP_TC_SH[tc]);
	// Unused gain codes fall back to unity
	assign gain_q = (gcode <= ADPP_GAIN_MAX) ? ADPP_GAIN_Q14[gcode] : ADPP_GAIN_Q14[0];

	assign mapped = adpp_hit(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = s_reg.prdata;

	// Room when not full, or when a word leaves in this same cycle
	assign in_ready = (s_reg.cnt != 2'h2) || out_ready;
	assign fire = in_valid && in_ready;
	// A stale phase must not swallow a sample once decimation is off
	assign emit = fire && (s_reg.dcnt == 3'h0 || dec_n == 4'h1);
	assign out_valid = s_reg.cnt != 2'h0;
	assign out_a = s_reg.fifo[s_reg.rp][11:0];
	assign out_b = s_reg.fifo[s_reg.rp][23:12];

	// Built-in sets are chosen only when user taps are not selected
	always_comb begin
		int set;
		set = (rate == ADPP_RATE_D4) ? 2 + int'(band) : int'(band[0]);
		for (int i = 0; i < ADPP_NCOEF; i++) begin
			hk[i] = user ? $signed(s_reg.coef[i]) : 12'(ADPP_BUILTIN[set][i]);
		end
	end

	always_comb begin
		int sum;
		int err;
		int a;
		int b;
		logic signed [43:0] est;
		logic signed [28:0] prod;
		logic [11:0] rd;
		sum = 0;
		err = 0;
		a = 0;
		b = 0;
		est = '0;
		prod = '0;
		rd = '0;
		s_next = s_reg;
		for (int c = 0; c < 2; c++) begin
			xs[c] = $signed((c == 0 ? in_a : in_b) ^ ADPP_MID);
			// Signed shift, so a negative offset gives a negative estimate
			est = $signed(s_reg.acc[c]) >>> tc_sh;
			est_y[c] = adpp_sat(int'(est));
			err = int'(xs[c]) - int'(est_y[c]);
			if (off_en) begin
				off_y[c] = adpp_sat(err);
				if (!freeze && fire) begin
					s_next.acc[c] = s_reg.acc[c] + 44'(err);
				end
			end else begin
				off_y[c] = xs[c];
				s_next.acc[c] = '0;
			end
			prod = off_y[c] * $signed({1'b0, gain_q});
			gain_y[c] = adpp_sat(int'((prod + 29'sd8192) >>> ADPP_GAIN_FRAC));
			if (fire) begin
				s_next.dly[c][0] = gain_y[c];
				for (int k = 1; k < ADPP_NTAP; k++) begin
					s_next.dly[c][k] = s_reg.dly[c][k-1];
				end
			end
			sum = 0;
			for (int i = 0; i < ADPP_NCOEF; i++) begin
				if (rate == ADPP_RATE_NODEC && !filt_en) begin
					a = (i >= 6) ? i - 6 : 0;
					b = (i >= 6) ? 17 - i : 0;
				end else if (odd) begin
					a = i;
					b = (i == 11) ? ADPP_NTAP : 22 - i;
				end else begin
					a = i;
					b = 23 - i;
				end
				if (!(rate == ADPP_RATE_NODEC && !filt_en) || i >= 6) begin
					sum = sum + int'(hk[i]) * (int'($signed(s_next.dly[c][a])) +
						(b < ADPP_NTAP ? int'($signed(s_next.dly[c][b])) : 0));
				end
			end
			fir_y[c] = adpp_sat((sum + 1024) >>> ADPP_COEF_FRAC);
			res_y[c] = lowlat ? xs[c] : (filt_on ? fir_y[c] : gain_y[c]);
		end
		if (fire) begin
			s_next.dcnt = ({1'b0, s_reg.dcnt} >= dec_n - 4'h1) ? 3'h0 :
				s_reg.dcnt + 3'h1;
		end
		if (emit) begin
			s_next.fifo[s_reg.wp] = {res_y[1] ^ ADPP_MID, res_y[0] ^ ADPP_MID};
			s_next.wp = !s_reg.wp;
		end
		if (out_valid && out_ready) begin
			s_next.rp = !s_reg.rp;
		end
		s_next.cnt = s_reg.cnt + 2'(emit) - 2'(out_valid && out_ready);
		if (psel && penable && pwrite && mapped) begin
			if (paddr == ADPP_CTRL_ADDR) begin
				s_next.ctrl = pwdata & ADPP_CTRL_MASK;
			end else if (paddr != ADPP_STAT_ADDR) begin
				s_next.coef[4'((paddr - ADPP_COEF_ADDR) >> 2)] = pwdata[11:0];
			end
		end
		// Read data is latched in the setup cycle so the access needs no wait
		if (psel && !penable) begin
			if (paddr == ADPP_CTRL_ADDR) begin
				rd = '0;
				s_next.prdata = s_reg.ctrl;
			end else if (paddr == ADPP_STAT_ADDR) begin
				s_next.prdata = {6'h0, s_reg.cnt, est_y[1], est_y[0]};
			end else if (mapped) begin
				rd = s_reg.coef[4'((paddr - ADPP_COEF_ADDR) >> 2)];
				s_next.prdata = {{20{rd[11]}}, rd};
			end else begin
				s_next.prdata = 32'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.ctrl <= ADPP_CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	sequence seq_emit;
		emit && dec_n != 4'h1;
	endsequence

	sequence seq_quiet;
		!emit;
	endsequence

	ctrl_reset_a: assert property (@(posedge clk) sys_rst |=> !off_en && !filt_en)
		else $error("control not cleared by reset");

	freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		off_en && freeze |=> $stable(s_reg.acc))
		else $error("offset estimate moved while frozen");

	tc_code_a: assert property (@(posedge clk) disable iff (sys_rst)
		(tc == 3'h5 |-> tc_sh == 6'd29) and (tc == 3'h7 |-> tc_sh == 6'd27))
		else $error("wrong loop time constant");

	off_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
		off_en && fire && !freeze && est_y[0] == 12'sd0 && xs[0] > 12'sd0
		|=> $signed(s_reg.acc[0]) > 44'sd0)
		else $error("offset loop did not integrate");

	gain_pos_a: assert property (@(posedge clk) disable iff (sys_rst)
		off_y[0] > 12'sd0 |-> gain_y[0] >= off_y[0])
		else $error("gain trim reduced a sample");

	gain_unity_a: assert property (@(posedge clk) disable iff (sys_rst)
		gcode == 4'h0 |-> gain_y[1] == off_y[1])
		else $error("zero gain code changed a sample");

	dec_space_a: assert property (@(posedge clk) disable iff (sys_rst)
		seq_emit ##1 $stable(s_reg.ctrl) |-> seq_quiet)
		else $error("decimation kept two results in a row");

	bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
		lowlat && fire |-> emit && res_y[0] == xs[0] && res_y[1] == xs[1])
		else $error("low latency mode did not bypass");

	nodec_on_a: assert property (@(posedge clk) disable iff (sys_rst)
		!lowlat && !filt_en && !(user && rate == ADPP_RATE_NODEC) |-> !filt_on)
		else $error("filter ran without enable");

	buf_full_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_reg.cnt == 2'h2 && !out_ready |-> !in_ready ##1 s_reg.cnt == 2'h2)
		else $error("buffer took a word while full");

	apb_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		psel && penable && !adpp_hit(paddr) |-> pslverr && pready)
		else $error("unmapped access not flagged");

	off_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		!off_en |=> s_reg.acc == '0)
		else $error("offset estimate kept while disabled");

	off_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		!off_en |-> off_y[0] == xs[0] && off_y[1] == xs[1])
		else $error("disabled offset stage changed a sample");

	filt_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		!lowlat && !filt_on |-> res_y[0] == gain_y[0] && res_y[1] == gain_y[1] && dec_n == 4'h1)
		else $error("disabled filter changed a sample");

	dec_eight_a: assert property (@(posedge clk) disable iff (sys_rst)
		filt_on && rate == ADPP_RATE_D8 |-> user && dec_n == 4'h8)
		else $error("decimation by eight without user taps");

	nodec_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		!lowlat && !filt_en && user && rate == ADPP_RATE_NODEC |-> filt_on && dec_n == 4'h1)
		else $error("no-decimation filter not running");

	dec_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		fire && dec_n == 4'h4 && s_reg.dcnt == 3'h3 |=> s_reg.dcnt == 3'h0)
		else $error("decimation phase did not wrap");

	gain_floor_a: assert property (@(posedge clk) disable iff (sys_rst)
		gain_q >= ADPP_GAIN_Q14[0])
		else $error("gain trim below unity");

	out_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_valid && !out_ready |=> out_valid && $stable(out_a) && $stable(out_b))
		else $error("buffered word changed before it was taken");
endmodule

//--- rtl/adpp_pkg.sv
// Notes on behaviour
// - Offset loop on: estimate each channel's dc offset, subtract it every sample.
// - Time constant field at bits 6:4 picks 2^24..2^29 clocks, spare codes 2^27.
// - Freeze stops estimate updates; last estimate keeps being subtracted.
// - Offset correction stays off after reset until software enables it.
// - With no input, the loop pulls average output code toward 2048.
// - Gain field at bits 3:0 adds 0.05 dB per step up to 0.5 dB.
// - Gain trim is positive only and common to both channels.
// - Filter off after reset; runs only when enabled, except no-decimation custom mode.
// - Rate 000 is /2, 001 is /4, 100 is /8, 011 filters without decimation.
// - Band field picks built-in low, high or band filters at rates 2 and 4.
// - User taps select uses loaded taps; /8 and no-decimation need it.
// - 24-tap symmetric FIR of 12-bit taps, sum divided by 2^11.
// - Odd-tap bit gives 23 taps with h11 alone at the centre.
// - Built-in selections use fixed tap sets held in the block.
// - No-decimation mode is a 12-tap FIR of h6..h11 mirrored, scaled 2^-11.
// - Low-latency mode bypasses offset, gain and filter entirely.
package adpp_pkg;
	localparam int ADPP_DW = 12;
	localparam int ADPP_AW = 8;
	localparam int ADPP_NCOEF = 12;
	localparam int ADPP_NTAP = 24;
	localparam int ADPP_ACC_W = 44;
	localparam logic [7:0] ADPP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] ADPP_COEF_ADDR = 8'h04;
	localparam logic [7:0] ADPP_STAT_ADDR = 8'h34;
	localparam logic [31:0] ADPP_CTRL_RST = 32'h0;
	localparam logic [31:0] ADPP_CTRL_MASK = 32'h0003_ffff;
	localparam int ADPP_GAIN_LSB = 0;
	localparam int ADPP_TC_LSB = 4;
	localparam int ADPP_OFF_EN_BIT = 7;
	localparam int ADPP_FREEZE_BIT = 8;
	localparam int ADPP_FILT_EN_BIT = 9;
	localparam int ADPP_RATE_LSB = 10;
	localparam int ADPP_BAND_LSB = 13;
	localparam int ADPP_USER_BIT = 15;
	localparam int ADPP_ODD_BIT = 16;
	localparam int ADPP_LOWLAT_BIT = 17;
	localparam logic [2:0] ADPP_RATE_D2 = 3'h0;
	localparam logic [2:0] ADPP_RATE_D4 = 3'h1;
	localparam logic [2:0] ADPP_RATE_D8 = 3'h4;
	localparam logic [2:0] ADPP_RATE_NODEC = 3'h3;
	localparam logic [3:0] ADPP_GAIN_MAX = 4'ha;
	localparam int ADPP_GAIN_FRAC = 14;
	localparam int ADPP_COEF_FRAC = 11;
	localparam logic [11:0] ADPP_MID = 12'h800;
	// Loop shift per time-constant code
	localparam int ADPP_TC_SH [8] = '{27, 26, 25, 24, 28, 29, 27, 27};
	// Unity is 2^14; step k is 10^(0.05k/20)
	localparam logic [15:0] ADPP_GAIN_Q14 [11] = '{16'h4000, 16'h405f, 16'h40be,
		16'h411e, 16'h417e, 16'h41df, 16'h4240, 16'h42a2, 16'h4304, 16'h4367, 16'h43cb};
	// Sets: lp/2, hp/2, then the four bands of /4
	localparam int ADPP_BUILTIN [6][12] = '{
		'{23, -37, -6, 68, -36, -61, 35, 118, -100, -197, 273, 943},
		'{-22, -65, -52, 30, 66, -35, -107, 38, 202, -41, -644, 1061},
		'{-17, -50, 71, 46, 24, -42, -100, -97, 8, 202, 414, 554},
		'{-7, 19, -47, 127, 73, 0, 86, 117, -190, -464, -113, 526},
		'{-34, -34, -101, 43, 58, -28, -5, -179, 294, 86, -563, 352},
		'{32, -15, -95, 22, -8, -81, 106, -62, -97, 310, -501, 575}};
	typedef struct packed {
		logic [31:0] ctrl;
		logic [11:0][11:0] coef;
		logic [1:0][43:0] acc;
		logic [1:0][23:0][11:0] dly;
		logic [2:0] dcnt;
		logic [1:0][23:0] fifo;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic [31:0] prdata;
	} adpp_state_t;
endpackage

//--- testbench/adpp_bench.sv
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t: %s", $time, m); end end
module adpp_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import adpp_pkg::*;
	localparam logic [31:0] FE = 32'h1 << ADPP_FILT_EN_BIT;
	localparam logic [31:0] UT = 32'h1 << ADPP_USER_BIT;
	logic clk = 0;
	logic sys_rst = 1;
	logic [ADPP_AW-1:0] paddr = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic in_valid = 0;
	logic in_ready;
	logic [11:0] in_a = 0;
	logic [11:0] in_b = 0;
	logic out_valid;
	logic out_ready;
	logic [11:0] out_a;
	logic [11:0] out_b;
	logic hold = 0;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 32'h7aba;
	always #5 clk = ~clk;
	adpp_core dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
		.in_a(in_a), .in_b(in_b), .out_valid(out_valid), .out_ready(out_ready),
		.out_a(out_a), .out_b(out_b));
	adpp_sink sink (.clk(clk), .hold(hold), .out_valid(out_valid),
		.out_ready(out_ready), .out_a(out_a), .out_b(out_b));
	function automatic logic [11:0] sat(int y);
		if (y > 2047) y = 2047;
		if (y < -2048) y = -2048;
		return 12'(y + 2048);
	endfunction
	function automatic logic [11:0] gexp(logic [11:0] x, logic [3:0] k);
		int g;
		g = (k > ADPP_GAIN_MAX) ? 16384 : int'(ADPP_GAIN_Q14[k]);
		return sat(((int'(x) - 2048) * g + 8192) >>> 14);
	endfunction
	// A steady input settles to the input times the summed taps
	function automatic logic [11:0] fexp(int s, int sm);
		return sat((s * sm + 1024) >>> 11);
	endfunction
	function automatic int bsum(int b);
		int t = 0;
		for (int i = 0; i < 12; i++)
			t += 2 * ADPP_BUILTIN[b][i];
		return t;
	endfunction
	function automatic logic [31:0] rt(logic [2:0] r);
		return 32'(r) << ADPP_RATE_LSB;
	endfunction
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Ready is combinational, so it is read at the falling edge once the sink has moved
	task automatic send(input logic [11:0] a, input logic [11:0] b);
		logic r;
		@(posedge clk);
		in_valid <= 1;
		in_a <= a;
		in_b <= b;
		do begin
			@(negedge clk);
			r = in_ready;
			@(posedge clk);
		end while (r !== 1'b1);
		in_valid <= 0;
		in_a <= ~a;
		in_b <= ~b;
	endtask
	task automatic drain();
		for (int i = 0; i < 40 && (i < 3 || out_valid !== 1'b0); i++)
			@(posedge clk);
	endtask
	// Sample counts stay multiples of 8 so the decimation phase is aligned
	task automatic run(input logic [31:0] c, input int div, input int sm, input logic [3:0] g);
		int sa;
		int sb;
		logic [11:0] xa;
		logic [11:0] xb;
		logic [11:0] ea [$];
		logic [11:0] eb [$];
		apb(1, ADPP_CTRL_ADDR, c);
		sink.qa.delete();
		sink.qb.delete();
		sa = $random(seed) % 256;
		sb = $random(seed) % 256;
		for (int i = 0; i < 32; i++) begin
			xa = (sm != 0) ? 12'(sa + 2048) : 12'($random(seed));
			xb = (sm != 0) ? 12'(sb + 2048) : 12'($random(seed));
			ea.push_back(gexp(xa, g));
			eb.push_back(gexp(xb, g));
			send(xa, xb);
		end
		drain();
		`CHK(sink.qa.size(), 32 / div, "count")
		if (sm != 0) begin
			`CHK(sink.qa[$], fexp(sa, sm), "filter a")
			`CHK(sink.qb[$], fexp(sb, sm), "filter b")
		end else
			foreach (ea[j]) `CHK({sink.qa[j], sink.qb[j]}, {ea[j], eb[j]}, "sample")
	endtask
	initial begin
		#200us;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		apb(0, ADPP_CTRL_ADDR, 0);
		`CHK({pready, rd}, {1'b1, ADPP_CTRL_RST}, "ctrl reset")
		apb(0, 8'h38, 0);
		`CHK({er, rd}, {1'b1, 32'h0}, "unmapped")
		for (int k = 0; k < 12; k++)
			run(32'(k), 1, 0, 4'(k));
		for (int i = 0; i < 12; i++)
			apb(1, ADPP_COEF_ADDR + 8'(4 * i), (i == 11) ? 32'd1024 : 32'd0);
		apb(0, ADPP_COEF_ADDR + 8'd44, 0);
		`CHK(rd, 32'd1024, "coef read")
		for (int b = 0; b < 6; b++)
			run(FE | rt((b < 2) ? ADPP_RATE_D2 : ADPP_RATE_D4) |
				32'(((b < 2) ? b : b - 2) << ADPP_BAND_LSB), (b < 2) ? 2 : 4, bsum(b), 0);
		run(FE | UT | 32'h6000 | rt(ADPP_RATE_D2), 2, 2048, 0);
		run(FE | UT | 32'h6000 | rt(ADPP_RATE_D4), 4, 2048, 0);
		run(FE | UT | rt(ADPP_RATE_D8), 8, 2048, 0);
		run(FE | UT | (32'h1 << ADPP_ODD_BIT), 2, 1024, 0);
		run(UT | rt(ADPP_RATE_NODEC), 1, 2048, 0);
		run(FE | rt(ADPP_RATE_D8), 1, 0, 0);
		run(rt(ADPP_RATE_D4), 1, 0, 0);
		// A small positive offset keeps the estimate at zero, so samples pass unchanged
		apb(1, ADPP_CTRL_ADDR, 32'hd0);
		sink.qa.delete();
		sink.qb.delete();
		for (int i = 0; i < 16; i++)
			send(12'h900, 12'h900);
		drain();
		`CHK(sink.qa.size(), 16, "offset count")
		`CHK({sink.qa[$], sink.qb[$]}, 24'h900900, "offset")
		apb(0, ADPP_STAT_ADDR, 0);
		`CHK(rd, 32'h0, "estimate")
		run(32'hb0 | (32'h1 << ADPP_FREEZE_BIT), 1, 0, 0);
		run(FE | UT | 32'hfa | (32'h1 << ADPP_LOWLAT_BIT), 1, 0, 0);
		apb(1, ADPP_CTRL_ADDR, 32'h1 << ADPP_LOWLAT_BIT);
		sink.qa.delete();
		sink.qb.delete();
		hold <= 1;
		send(12'h123, 12'h456);
		send(12'h789, 12'habc);
		@(negedge clk);
		`CHK({out_valid, in_ready}, 2'b10, "full")
		apb(0, ADPP_STAT_ADDR, 0);
		`CHK(rd, 32'h0200_0000, "fill")
		@(posedge clk);
		hold <= 0;
		drain();
		`CHK({sink.qa[0], sink.qb[1]}, {12'h123, 12'habc}, "order")
		close_out();
	end
endmodule

//--- testbench/adpp_sink.sv
module adpp_sink (
	// Clock
	input wire logic clk,
	// Stalls the sink fully while high
	input wire logic hold,
	// Stream from the block
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [adpp_pkg::ADPP_DW-1:0] out_a,
	input wire logic [adpp_pkg::ADPP_DW-1:0] out_b
);
	timeunit 1ns;
	timeprecision 1ps;
	import adpp_pkg::*;
	logic [ADPP_DW-1:0] qa [$];
	logic [ADPP_DW-1:0] qb [$];
	int seed = 32'h7aba;
	initial out_ready = 1'b0;
	// Random stalls keep the two-entry buffer partly full
	always @(posedge clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			qa.push_back(out_a);
			qb.push_back(out_b);
		end
		out_ready <= !hold && ($random(seed) % 3 != 0);
	end
endmodule
